// ===== pkg/cfl_pkg.sv
package cfl_pkg;

  // ==========================================================
  // Register map (APB byte addresses).
  // ==========================================================
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] OWN_LEN_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] LEN_CNT_OFS = 8'h0c;
  localparam logic [7:0] CLK_CNT_OFS = 8'h10;

  // Control register fields.
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_FAST_BIT = 1;
  localparam int CTRL_AUX1_BIT = 2;
  localparam int CTRL_HIGH_BIT = 3;
  localparam int CTRL_LOW_BIT = 4;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [23:0] OWN_LEN_RST = 24'h000100;

  // Status register fields.
  localparam int ST_STATE_LSB = 0;
  localparam int ST_MODE_LSB = 4;
  localparam int ST_PHASE_LSB = 8;
  localparam int ST_ERR_BIT = 12;
  localparam int ST_FAST_BIT = 13;

  // ==========================================================
  // Mode codes, ordered bit2, bit1, bit0.
  // ==========================================================
  localparam logic [2:0] MODE_MSER = 3'h0;
  localparam logic [2:0] MODE_SSER = 3'h7;
  localparam logic [2:0] MODE_PUP = 3'h4;
  localparam logic [2:0] MODE_PDN = 3'h6;
  localparam logic [2:0] MODE_PSYNC = 3'h3;
  localparam logic [2:0] MODE_PASYNC = 3'h5;

  // ==========================================================
  // Bitstream header.
  // ==========================================================
  localparam logic [3:0] PREAMBLE = 4'h2;
  localparam int LEN_W = 24;
  localparam logic [4:0] LEN_LAST = 5'h17;
  localparam logic [1:0] STARTUP_CCLKS = 2'h2;

  // ==========================================================
  // Timing.
  // ==========================================================
  localparam longint CLK_HZ = 100_000_000;
  localparam longint CONFIG_CLOCK_SLOW_HZ = 1_000_000;
  localparam longint CONFIG_CLOCK_FAST_HZ = 8_000_000;
  // Half periods round down so the clock never runs slower than set.
  localparam logic [7:0] HALF_SLOW = 8'(CLK_HZ / (2 * CONFIG_CLOCK_SLOW_HZ));
  localparam logic [7:0] HALF_FAST = 8'(CLK_HZ / (2 * CONFIG_CLOCK_FAST_HZ));

  // Top-level load sequence.
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_LOAD = 4'h2,
    ST_START = 4'h4,
    ST_DONE = 4'h8
  } cfl_state_t;

  // Bitstream header tracker.
  typedef enum logic [3:0] {
    PH_SEEK = 4'h1,
    PH_LEN = 4'h2,
    PH_OWN = 4'h4,
    PH_PASS = 4'h8
  } cfl_phase_t;

endpackage

// ===== src/cfl_loader.sv
`timescale 1ns/1ps
// ============================================================
// Configuration mode decoder, bitstream loader and chain port.
// ============================================================
module cfl_loader #(
  parameter int ADDR_W = 18
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mode_sel_bit2,
  input wire logic mode_sel_bit1,
  input wire logic mode_sel_bit0,
  output logic mode_sel_bit1_out,
  output logic mode_sel_bit1_oe,
  output logic aux_user_in2,
  output logic aux_user_in0,
  input wire logic config_clock_in,
  output logic config_clock_out,
  output logic config_clock_oe,
  input wire logic serial_cfg_in,
  input wire logic [7:0] prom_data,
  output logic [ADDR_W-1:0] prom_addr,
  output logic chain_data_out,
  output logic config_error_n,
  output logic high_while_loading,
  output logic low_while_loading,
  output logic user_io_active
);

  // ==========================================================
  // Pin synchronisers.
  // ==========================================================
  logic [12:0] pins_s; // Filtered copies of all foreign inputs.
  cfl_sync #(.W(13)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .pin_in({mode_sel_bit2, mode_sel_bit1, mode_sel_bit0,
             config_clock_in, serial_cfg_in, prom_data}),
    .sync_out(pins_s)
  );
  logic [2:0] mode_pins; // Mode pins, bit2 first.
  logic config_clock_s; // Clock from outside.
  logic din_s; // Serial data.
  logic [7:0] byte_s; // Byte-wide data.
  assign mode_pins = pins_s[12:10];
  assign config_clock_s = pins_s[9];
  assign din_s = pins_s[8];
  assign byte_s = pins_s[7:0];

  // ==========================================================
  // Registers and state.
  // ==========================================================
  cfl_pkg::cfl_state_t state_r; // Load sequence.
  cfl_pkg::cfl_phase_t phase_r; // Header tracker.
  logic [4:0] ctrl_r; // Control bits; start self-clears.
  logic [23:0] own_len_r; // Bits of this device's own frames.
  logic [2:0] mode_r; // Mode latched at start.
  logic fast_r; // Fast clock rate in use.
  logic err_r; // Sticky data error.
  logic [7:0] div_r; // Clock divider.
  logic config_clock_r; // Generated clock level.
  logic config_clock_prev_r; // Previous external clock level.
  logic [3:0] pre_r; // Last received bits.
  logic [4:0] lbit_r; // Length field bit index.
  logic [23:0] len_r; // Captured length count.
  logic [23:0] own_cnt_r; // Own frame bits received.
  logic [23:0] ccnt_r; // Clock cycles since loading began.
  logic [1:0] su_r; // Start-up clock count.
  logic [7:0] sh_r; // Byte serialiser.
  logic [2:0] bcnt_r; // Bits left in the serialiser.
  logic have_r; // Serialiser holds a byte.
  logic out_pend_r; // Bit waiting for the next falling edge.

  // ==========================================================
  // Mode decode.
  // ==========================================================
  logic master_m; // This device makes the clock.
  logic serial_m; // Data arrives one bit per clock.
  logic par_m; // Master parallel, drives addresses.
  always_comb begin
    master_m = 1'b0;
    serial_m = 1'b0;
    par_m = 1'b0;
    unique case (mode_r)
      cfl_pkg::MODE_MSER: begin
        master_m = 1'b1;
        serial_m = 1'b1;
      end
      cfl_pkg::MODE_SSER: begin
        serial_m = 1'b1;
      end
      cfl_pkg::MODE_PUP, cfl_pkg::MODE_PDN: begin
        master_m = 1'b1;
        par_m = 1'b1;
      end
      cfl_pkg::MODE_PASYNC: begin
        master_m = 1'b1;
      end
      cfl_pkg::MODE_PSYNC: begin
        master_m = 1'b0;
      end
      default: begin
        // The two spare codes fall back to the pull-up default.
        serial_m = 1'b1;
      end
    endcase
  end

  logic loading; // Clock edges matter in load and start-up.
  assign loading = (state_r == cfl_pkg::ST_LOAD) || (state_r == cfl_pkg::ST_START);

  // ==========================================================
  // Configuration clock generation and edge detection.
  // ==========================================================
  logic [7:0] half_cnt; // Current half period in pclk cycles.
  assign half_cnt = fast_r ? cfl_pkg::HALF_FAST : cfl_pkg::HALF_SLOW;

  // The divider runs only while loading, so every slow start is clean.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 8'h00;
      config_clock_r <= 1'b0;
    end else if (clk_en) begin
      if (!loading || !master_m) begin
        div_r <= 8'h00;
        config_clock_r <= 1'b0;
      end else if (div_r == half_cnt - 8'h01) begin
        div_r <= 8'h00;
        config_clock_r <= ~config_clock_r;
      end else begin
        div_r <= div_r + 8'h01;
      end
    end
  end

  // Remember the filtered external clock for edge finding.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_clock_prev_r <= 1'b0;
    end else if (clk_en) begin
      config_clock_prev_r <= config_clock_s;
    end
  end

  logic tick; // Generated clock is about to toggle.
  logic rise_ev; // Rising configuration clock edge.
  logic fall_ev; // Falling configuration clock edge.
  assign tick = loading && master_m && (div_r == half_cnt - 8'h01);
  assign rise_ev = master_m ? (tick && !config_clock_r) : (loading && config_clock_s && !config_clock_prev_r);
  assign fall_ev = master_m ? (tick && config_clock_r) : (loading && !config_clock_s && config_clock_prev_r);

  // ==========================================================
  // Data capture: serial bits or serialised bytes.
  // ==========================================================
  logic bit_ok; // A data bit is taken at this rising edge.
  logic bit_now; // Its value.
  assign bit_ok = rise_ev && (state_r == cfl_pkg::ST_LOAD) && (serial_m || have_r);
  assign bit_now = serial_m ? din_s : sh_r[0];

  // A byte is taken at one rise; its LSB is used at the next rise and
  // leaves on the fall after it, 1.5 periods in all.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_r <= 8'h00;
      bcnt_r <= 3'h0;
      have_r <= 1'b0;
    end else if (clk_en) begin
      if (state_r == cfl_pkg::ST_IDLE) begin
        have_r <= 1'b0;
      end else if (rise_ev && !serial_m && state_r == cfl_pkg::ST_LOAD) begin
        if (!have_r || bcnt_r == 3'h0) begin
          sh_r <= byte_s;
          bcnt_r <= 3'h7;
          have_r <= 1'b1;
        end else begin
          sh_r <= {1'b0, sh_r[7:1]};
          bcnt_r <= bcnt_r - 3'h1;
        end
      end
    end
  end

  logic byte_take; // A new byte is accepted at this edge.
  assign byte_take = rise_ev && !serial_m && (state_r == cfl_pkg::ST_LOAD)
                     && (!have_r || bcnt_r == 3'h0);

  // In the up and down modes the PROM address steps as each byte is accepted.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prom_addr <= '0;
    end else if (clk_en) begin
      if (state_r == cfl_pkg::ST_IDLE) begin
        // Down mode starts at the top of the address space.
        prom_addr <= (mode_pins == cfl_pkg::MODE_PDN) ? '1 : '0;
      end else if (byte_take && par_m) begin
        if (mode_r == cfl_pkg::MODE_PDN) begin
          prom_addr <= prom_addr - 1'b1;
        end else begin
          prom_addr <= prom_addr + 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Header tracking and daisy-chain output.
  // ==========================================================
  logic [3:0] pre_nxt; // Preamble window including this bit.
  assign pre_nxt = {pre_r[2:0], bit_now};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= cfl_pkg::PH_SEEK;
      pre_r <= 4'hf;
      lbit_r <= 5'h00;
      len_r <= 24'h000000;
      own_cnt_r <= 24'h000000;
      out_pend_r <= 1'b1;
    end else if (clk_en) begin
      if (state_r == cfl_pkg::ST_IDLE) begin
        phase_r <= cfl_pkg::PH_SEEK;
        pre_r <= 4'hf;
        own_cnt_r <= 24'h000000;
        out_pend_r <= 1'b1;
      end else if (bit_ok) begin
        unique case (phase_r)
          cfl_pkg::PH_SEEK: begin
            pre_r <= pre_nxt;
            out_pend_r <= bit_now;
            if (pre_nxt == cfl_pkg::PREAMBLE) begin
              phase_r <= cfl_pkg::PH_LEN;
              lbit_r <= 5'h00;
            end
          end
          cfl_pkg::PH_LEN: begin
            len_r <= {len_r[22:0], bit_now};
            lbit_r <= lbit_r + 5'h01;
            out_pend_r <= bit_now;
            if (lbit_r == cfl_pkg::LEN_LAST) begin
              phase_r <= (own_len_r == 24'h000000) ? cfl_pkg::PH_PASS : cfl_pkg::PH_OWN;
            end
          end
          cfl_pkg::PH_OWN: begin
            out_pend_r <= 1'b1;
            own_cnt_r <= own_cnt_r + 24'h000001;
            if (own_cnt_r == own_len_r - 24'h000001) begin
              phase_r <= cfl_pkg::PH_PASS;
            end
          end
          cfl_pkg::PH_PASS: begin
            out_pend_r <= bit_now;
          end
        endcase
      end
    end
  end

  // The chain output only changes on a falling configuration edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain_data_out <= 1'b1;
    end else if (clk_en) begin
      // Start-up still has two falls to come; the first carries the last bit on.
      if (fall_ev && loading) begin
        chain_data_out <= out_pend_r;
      end else if (state_r == cfl_pkg::ST_IDLE) begin
        chain_data_out <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Load sequence, clock count and start-up.
  // ==========================================================
  logic [23:0] ccnt_nxt; // Clock count after this rising edge.
  logic len_known; // Length field fully captured.
  logic start_req; // Software start strobe.
  assign ccnt_nxt = ccnt_r + 24'h000001;
  assign len_known = (phase_r == cfl_pkg::PH_OWN) || (phase_r == cfl_pkg::PH_PASS);
  assign start_req = psel && penable && pwrite && (paddr == cfl_pkg::CTRL_OFS)
                     && pwdata[cfl_pkg::CTRL_START_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= cfl_pkg::ST_IDLE;
      mode_r <= cfl_pkg::MODE_SSER;
      ccnt_r <= 24'h000000;
      su_r <= 2'h0;
    end else if (clk_en) begin
      unique case (state_r)
        cfl_pkg::ST_IDLE, cfl_pkg::ST_DONE: begin
          if (start_req) begin
            // Pins float high through pull-ups, so an open set
            // reads as slave serial.
            mode_r <= mode_pins;
            ccnt_r <= 24'h000000;
            su_r <= 2'h0;
            state_r <= cfl_pkg::ST_LOAD;
          end
        end
        cfl_pkg::ST_LOAD: begin
          if (rise_ev) begin
            ccnt_r <= ccnt_nxt;
            if (len_known && ccnt_nxt == len_r) begin
              state_r <= cfl_pkg::ST_START;
            end
          end
        end
        cfl_pkg::ST_START: begin
          if (rise_ev) begin
            su_r <= su_r + 2'h1;
            if (su_r == cfl_pkg::STARTUP_CCLKS - 2'h1) begin
              state_r <= cfl_pkg::ST_DONE;
            end
          end
        end
        default: begin
          state_r <= cfl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Fast rate is allowed only once the first frame has begun.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_r <= 1'b0;
    end else if (clk_en) begin
      if (!loading) begin
        fast_r <= 1'b0;
      end else if (len_known && ctrl_r[cfl_pkg::CTRL_FAST_BIT] && !config_clock_r) begin
        fast_r <= 1'b1;
      end
    end
  end

  // A length count that ends on or before the last bit of this device's own
  // frames is a broken stream; it stays flagged until the next start.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_r <= 1'b0;
    end else if (clk_en) begin
      if (start_req && state_r != cfl_pkg::ST_LOAD && state_r != cfl_pkg::ST_START) begin
        err_r <= 1'b0;
      end else if (rise_ev && state_r == cfl_pkg::ST_LOAD && len_known
                   && ccnt_nxt == len_r && phase_r == cfl_pkg::PH_OWN) begin
        err_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Pin outputs.
  // ==========================================================
  logic done; // User I/O released.
  assign done = (state_r == cfl_pkg::ST_DONE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_clock_out <= 1'b0;
      config_clock_oe <= 1'b0;
      config_error_n <= 1'b1;
      high_while_loading <= 1'b1;
      low_while_loading <= 1'b0;
      user_io_active <= 1'b0;
      mode_sel_bit1_out <= 1'b0;
      mode_sel_bit1_oe <= 1'b0;
      aux_user_in2 <= 1'b0;
      aux_user_in0 <= 1'b0;
    end else if (clk_en) begin
      // Take the divider's next level so the pin moves on the same edge as the
      // chain output and the address, not one system clock behind them.
      config_clock_out <= (loading && master_m) ? (config_clock_r ^ tick) : 1'b0;
      config_clock_oe <= loading && master_m;
      config_error_n <= !(err_r && !done);
      user_io_active <= done;
      // The loading flags become plain user outputs once released.
      high_while_loading <= done ? ctrl_r[cfl_pkg::CTRL_HIGH_BIT] : 1'b1;
      low_while_loading <= done ? ctrl_r[cfl_pkg::CTRL_LOW_BIT] : 1'b0;
      mode_sel_bit1_out <= ctrl_r[cfl_pkg::CTRL_AUX1_BIT];
      mode_sel_bit1_oe <= done;
      aux_user_in2 <= done && mode_pins[2];
      aux_user_in0 <= done && mode_pins[0];
    end
  end

  // ==========================================================
  // APB slave: zero wait states, error on unmapped addresses.
  // ==========================================================
  logic mapped; // Address hits a register.
  assign mapped = (paddr == cfl_pkg::CTRL_OFS) || (paddr == cfl_pkg::OWN_LEN_OFS)
                  || (paddr == cfl_pkg::STATUS_OFS) || (paddr == cfl_pkg::LEN_CNT_OFS)
                  || (paddr == cfl_pkg::CLK_CNT_OFS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Writes land at the access edge; start is never stored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= cfl_pkg::CTRL_RST;
      own_len_r <= cfl_pkg::OWN_LEN_RST;
    end else if (clk_en && psel && penable && pwrite) begin
      if (paddr == cfl_pkg::CTRL_OFS) begin
        ctrl_r <= {pwdata[4:1], 1'b0};
      end else if (paddr == cfl_pkg::OWN_LEN_OFS && !loading) begin
        // Changing the frame size mid-load would corrupt the count.
        own_len_r <= pwdata[23:0];
      end
    end
  end

  // Read data is registered in the setup cycle, valid in access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (clk_en && psel && !penable) begin
      unique case (paddr)
        cfl_pkg::CTRL_OFS: prdata <= {27'h0, ctrl_r};
        cfl_pkg::OWN_LEN_OFS: prdata <= {8'h00, own_len_r};
        cfl_pkg::STATUS_OFS: prdata <= {18'h0, fast_r, err_r, phase_r, 1'b0, mode_r, state_r};
        cfl_pkg::LEN_CNT_OFS: prdata <= {8'h00, len_r};
        cfl_pkg::CLK_CNT_OFS: prdata <= {8'h00, ccnt_r};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

endmodule // cfl_loader

// ===== src/cfl_sync.sv
`timescale 1ns/1ps
// ============================================================
// Three-stage pin synchroniser with agreement filter.
// ============================================================
module cfl_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_r; // First stage, read only by s2_r.
  logic [W-1:0] s2_r; // Second stage.
  logic [W-1:0] s3_r; // Third stage.

  // The output follows a bit only once stages two and three agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          sync_out[i] <= s3_r[i];
        end
      end
    end
  end
endmodule // cfl_sync

// ===== testbench/cfl_loader_assertions.sv
`timescale 1ns/1ps
// ============================================================
// Port-level checks on the loader.
// ============================================================
module cfl_loader_chk #(
  parameter int ADDR_W = 18
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] prom_addr,
  input wire logic config_clock_out,
  input wire logic config_clock_oe,
  input wire logic chain_data_out,
  input wire logic config_error_n,
  input wire logic high_while_loading,
  input wire logic low_while_loading,
  input wire logic user_io_active,
  input wire logic mode_sel_bit1_oe,
  input wire logic aux_user_in2,
  input wire logic aux_user_in0
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Outputs leave reset in their idle, loading-not-finished levels.
  reset_idle_a: assert property ($rose(presetn) |-> chain_data_out && config_error_n
    && high_while_loading && !low_while_loading) else $error("idle levels wrong after reset");
  loading_flags_a: assert property (!user_io_active |-> high_while_loading
    && !low_while_loading) else $error("loading flags wrong before release");
  aux_quiet_a: assert property (!user_io_active |-> !aux_user_in2 && !aux_user_in0
    && !mode_sel_bit1_oe) else $error("aux pins active before release");
  aux_release_a: assert property ($rose(user_io_active) |-> ##[0:1] mode_sel_bit1_oe)
    else $error("aux output not enabled at release");
  clk_drive_a: assert property (user_io_active |-> !config_clock_oe)
    else $error("config clock driven after release");
  chain_fall_a: assert property (config_clock_oe && $changed(chain_data_out)
    |-> $fell(config_clock_out)) else $error("chain output moved off a falling edge");
  addr_step_a: assert property (config_clock_oe && $changed(prom_addr)
    |-> $rose(config_clock_out)) else $error("address moved off a rising edge");
  low_time_a: assert property ($fell(config_clock_out) && config_clock_oe
    |=> !config_clock_out [*4]) else $error("config clock low time too short");
  err_window_a: assert property (!config_error_n |-> !user_io_active)
    else $error("error output low after release");
  // Between them the main scenarios reach each of these points.
  release_c: cover property ($rose(user_io_active));
  error_c: cover property ($fell(config_error_n));
  step_c: cover property (config_clock_oe && $changed(prom_addr));
endmodule // cfl_loader_chk

bind cfl_loader cfl_loader_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// ===== testbench/cfl_loader_tb.sv
`timescale 1ns/1ps
// ============================================================
// Self-checking bench for the loader.
// ============================================================
module cfl_loader_tb;
  logic pclk = 1'h0, presetn = 1'h0, clk_en = 1'h1, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, config_clock_in = 1'h0, pready, pslverr, err_q;
  logic mode_sel_bit2 = 1'h1, mode_sel_bit1 = 1'h1, mode_sel_bit0 = 1'h1;
  logic mode_sel_bit1_out, mode_sel_bit1_oe, aux_user_in2, aux_user_in0;
  logic config_clock_out, config_clock_oe, serial_cfg_in, chain_data_out, config_error_n;
  logic high_while_loading, low_while_loading, user_io_active;
  logic [7:0] paddr = 8'h00, prom_data;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [17:0] prom_addr;
  logic [47:0] cap;
  int num_errors = 0, check_count = 0, nr;
  // Filler, start pattern, length 48, eight own bits, eight bits for the chain.
  localparam logic [47:0] STREAM = {4'hf, cfl_pkg::PREAMBLE, 24'h000030, 8'h3c, 8'ha5};
  localparam logic [2:0] MODES [6] = '{cfl_pkg::MODE_MSER, cfl_pkg::MODE_SSER,
    cfl_pkg::MODE_PUP, cfl_pkg::MODE_PDN, cfl_pkg::MODE_PSYNC, cfl_pkg::MODE_PASYNC};

  always #5 pclk = ~pclk;
  cfl_loader i_dut (.*);
  cfl_prom_model #(.BITS(STREAM)) i_prom (.rst_n(presetn), .config_clock(config_clock_out),
    .addr(prom_addr), .sdata(serial_cfg_in), .bdata(prom_data));

  // The next device samples the chain line at each rise; keep falls 1 to 48.
  always @(posedge config_clock_out or negedge presetn) begin
    if (!presetn) nr <= 0;
    else begin
      nr <= nr + 1;
      if (nr >= 1 && nr <= 48) cap <= {cap[46:0], chain_data_out};
    end
  end

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Reset with the given pins, let them settle, set own length, then start.
  task automatic go(input logic [2:0] c, input logic [31:0] own);
    {mode_sel_bit2, mode_sel_bit1, mode_sel_bit0} <= c;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(1'b1, cfl_pkg::OWN_LEN_OFS, own, q);
    apb(1'b1, cfl_pkg::CTRL_OFS, 32'h15, q);
  endtask

  task automatic close_out();
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    logic [2:0] c;
    // Each of the six named mode codes; pins flip after start and must not disturb the latched mode.
    for (int i = 0; i < 6; i++) begin
      c = MODES[i];
      go(c, 32'h100);
      {mode_sel_bit2, mode_sel_bit1, mode_sel_bit0} <= ~c;
      repeat (20) @(posedge pclk);
      apb(1'b0, cfl_pkg::STATUS_OFS, 32'h0, q);
      chk({q[6:0], config_clock_oe}, {c, 4'h2, ~(c[1] & c[0])});
      if (c == cfl_pkg::MODE_PUP || c == cfl_pkg::MODE_PDN) begin
        repeat (17) @(posedge config_clock_out);
        repeat (3) @(posedge pclk);
        chk(prom_addr, (c == cfl_pkg::MODE_PUP) ? 18'h00003 : 18'h3fffc);
      end
    end
    // Full serial load with eight own bits, then the aux pins after release.
    go(cfl_pkg::MODE_MSER, 32'h8);
    wait (user_io_active === 1'b1);
    @(posedge pclk);
    {mode_sel_bit2, mode_sel_bit1, mode_sel_bit0} <= 3'h4;
    repeat (6) @(posedge pclk);
    chk(cap, {STREAM[47:16], 8'hff, STREAM[7:0]});
    apb(1'b0, cfl_pkg::LEN_CNT_OFS, 32'h0, q);
    chk(q, 32'h30);
    apb(1'b0, cfl_pkg::CLK_CNT_OFS, 32'h0, q);
    chk(q, 32'h30);
    apb(1'b0, cfl_pkg::STATUS_OFS, 32'h0, q);
    chk({q[12], q[3:0]}, 5'h08);
    chk({high_while_loading, low_while_loading, mode_sel_bit1_out, mode_sel_bit1_oe,
      aux_user_in2, aux_user_in0}, 6'h1e);
    apb(1'b0, 8'h40, 32'h0, q);
    chk({err_q, q}, {1'b1, 32'h0});
    // Own length too long for the count: the error output must drop.
    go(cfl_pkg::MODE_MSER, 32'h20);
    wait (nr == 49);
    repeat (5) @(posedge pclk);
    chk(config_error_n, 1'b0);
    close_out();
  end

  initial begin
    repeat (40000) @(posedge pclk);
    num_errors++;
    close_out();
  end
endmodule // cfl_loader_tb

// ===== testbench/cfl_prom_model.sv
`timescale 1ns/1ps
// ============================================================
// Serial and byte-wide configuration PROM.
// ============================================================
module cfl_prom_model #(
  parameter logic [47:0] BITS = 48'h0
) (
  input wire logic rst_n,
  input wire logic config_clock,
  input wire logic [17:0] addr,
  output logic sdata,
  output logic [7:0] bdata
);
  int idx;
  // Moving on at the falling edge keeps the bit settled across the next rise.
  always @(negedge config_clock or negedge rst_n) begin
    if (!rst_n) idx <= 0;
    else idx <= idx + 1;
  end
  // Past the image the output idles high, like filler.
  assign sdata = (idx < 48) ? BITS[47 - idx] : 1'b1;
  // Byte data follows address bits 7 to 0, so a wrong address in those bits shows up as wrong data.
  assign bdata = ~addr[7:0];
endmodule // cfl_prom_model
